// File: verilog/timed_output_scheduler.v
// timed output scheduler: entry image, queue, ticker and status
// Operation
// - five four-byte entries at consecutive offsets
// - entry holds time; pattern bits 7..4 drive channels
// - written entries are queued behind pending ones
// - ticker match applies head pattern, then drops it
// - entries run strictly in queue order
// - status word: last, next, queue status, count
// - image lengths fixed at four and 14h bytes
`timescale 1ns/1ps
`include "sched_consts.vh"
module timed_output_scheduler (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [3:0] channel_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function is_entry;
    input [7:0] adr;
    begin
      is_entry = (adr < `OFS_ENTRY_END) && (adr[1:0] == 2'b00);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] sel;
    integer b;
    begin
      merge = old_w;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = new_w[b*8 +: 8];
        end
      end
    end
  endfunction

  localparam integer TICK_LAST_FULL = `TICK_CYCLES - 1;
  localparam [4:0] TICK_LAST = TICK_LAST_FULL[4:0];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg [31:0] image_q [0:`ENTRY_COUNT-1];
  wire req;
  wire entry_hit;
  wire [2:0] entry_idx;
  wire [31:0] entry_word;
  wire buf_in_valid;
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_ready;
  wire [31:0] buf_out_data;
  wire ack_now;
  reg [31:0] read_d;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign entry_hit = is_entry(wb_adr_i);
  assign entry_idx = wb_adr_i[4:2];
  assign entry_word = merge(image_q[entry_idx], wb_dat_i, wb_sel_i);
  assign buf_in_valid = req & wb_we_i & entry_hit;
  // entry writes stall until the buffer can take the word
  assign ack_now = req & (~buf_in_valid | buf_in_ready);

  // ----------------------------------------------------------------
  // queue and ticker state
  // ----------------------------------------------------------------
  reg [31:0] queue_q [0:31];
  reg [4:0] wr_ptr_q;
  reg [4:0] rd_ptr_q;
  reg [5:0] count_q;
  reg [4:0] prescale_q;
  reg [15:0] ticker_q;
  reg [7:0] last_received_sequence_q;
  reg [7:0] next_expected_sequence_q;
  reg final_seen_q;
  wire push;
  wire pop;
  wire [31:0] head;
  wire [7:0] queue_status_byte;
  wire [7:0] pending_entry_count;

  assign head = queue_q[rd_ptr_q];
  assign buf_out_ready = (count_q != 6'd32);
  assign push = buf_out_valid & buf_out_ready;
  assign pop = (count_q != 6'd0) && (ticker_q == head[`TIME_HI:`TIME_LO]);

  assign queue_status_byte = {final_seen_q, 5'b00000, (count_q != 6'd0),
                              (count_q == 6'd32)};
  assign pending_entry_count = {2'b00, count_q};

  always @* begin
    read_d = 32'h00000000;
    if (entry_hit) begin
      read_d = image_q[entry_idx];
    end else if (wb_adr_i == `OFS_STATUS) begin
      read_d = {pending_entry_count, queue_status_byte,
                next_expected_sequence_q, last_received_sequence_q};
    end else if (wb_adr_i == `OFS_LENGTH) begin
      read_d = {16'h0000, `OUTPUT_IMAGE_LEN, `INPUT_IMAGE_LEN};
    end else begin
      read_d = 32'h00000000;
    end
  end

  two_entry_buffer u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(entry_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // ----------------------------------------------------------------
  // bus answer and entry image
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      for (i = 0; i < `ENTRY_COUNT; i = i + 1) begin
        image_q[i] <= 32'h00000000;
      end
    end else begin
      wb_ack_o <= ack_now;
      if (ack_now) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : read_d;
      end
      if (buf_in_valid & buf_in_ready) begin
        image_q[entry_idx] <= entry_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // microsecond ticker
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      prescale_q <= 5'd0;
      ticker_q <= 16'h0000;
    end else if (prescale_q == TICK_LAST) begin
      prescale_q <= 5'd0;
      ticker_q <= ticker_q + 16'h0001;
    end else begin
      prescale_q <= prescale_q + 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // entry queue
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (push) begin
      queue_q[wr_ptr_q] <= buf_out_data;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= 5'd0;
      rd_ptr_q <= 5'd0;
      count_q <= 6'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 5'd1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 5'd1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 6'd1;
      end else if (pop & ~push) begin
        count_q <= count_q - 6'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs and status
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_o <= 4'h0;
      next_expected_sequence_q <= `NEXT_RESET;
    end else if (pop) begin
      // channel 0 sits in bit 7 of the pattern byte
      channel_o <= {head[`CH_HI-3], head[`CH_HI-2], head[`CH_HI-1], head[`CH_HI]};
      next_expected_sequence_q <= `NEXT_BASE |
        {2'b00, head[`SEQ_LO+5:`SEQ_LO] + 6'd1};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      last_received_sequence_q <= `LAST_RESET;
      final_seen_q <= 1'b0;
    end else if (buf_in_valid & buf_in_ready) begin
      last_received_sequence_q <= entry_word[`SEQ_HI:`SEQ_LO];
      final_seen_q <= entry_word[`FINAL_BIT];
    end
  end
endmodule // timed_output_scheduler

// File: verilog/sched_consts.vh
// constants for the timed output scheduler
`ifndef SCHED_CONSTS_VH
`define SCHED_CONSTS_VH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define OFS_ENTRY0 8'h00
`define OFS_ENTRY_END 8'h14
`define OFS_STATUS 8'h20
`define OFS_LENGTH 8'h24
`define ENTRY_COUNT 5
// ----------------------------------------------------------------
// entry word fields
// ----------------------------------------------------------------
`define PAT_HI 31
`define PAT_LO 24
`define CH_HI 31
`define CH_LO 28
`define SEQ_HI 23
`define SEQ_LO 16
`define FINAL_BIT 22
`define TIME_HI 15
`define TIME_LO 0
// ----------------------------------------------------------------
// status values
// ----------------------------------------------------------------
`define INPUT_IMAGE_LEN 8'h04
`define OUTPUT_IMAGE_LEN 8'h14
`define NEXT_BASE 8'hc0
`define NEXT_RESET 8'hc1
`define LAST_RESET 8'h00
`define STS_FULL_BIT 0
`define STS_BUSY_BIT 1
`define STS_FINAL_BIT 7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TICK_NS 1000
`define CLK_PERIOD_NS 50
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/two_entry_buffer.v
// two-entry buffer between the bus and the entry queue
`timescale 1ns/1ps
module two_entry_buffer (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [31:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [31:0] out_data_o
);
  reg [31:0] slot0_q;
  reg [31:0] slot1_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != 2'd2);
  assign out_valid_o = (cnt_q != 2'd0);
  assign out_data_o = slot0_q;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      slot0_q <= 32'h00000000;
      slot1_q <= 32'h00000000;
      cnt_q <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'd0) begin
            slot0_q <= in_data_i;
          end else begin
            slot1_q <= in_data_i;
          end
          cnt_q <= cnt_q + 2'd1;
        end
        2'b01: begin
          slot0_q <= slot1_q;
          cnt_q <= cnt_q - 2'd1;
        end
        2'b11: begin
          if (cnt_q == 2'd1) begin
            slot0_q <= in_data_i;
          end else begin
            slot0_q <= slot1_q;
            slot1_q <= in_data_i;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end
endmodule // two_entry_buffer

// File: tb/timed_output_scheduler_properties.sv
// bus and output checks for the timed output scheduler
`timescale 1ns/1ps
module sched_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [3:0] channel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  endsequence
  sequence s_len;
    s_rd ##0 (wb_adr_i == 8'h24);
  endsequence
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_read_prompt: assert property (s_rd |=> wb_ack_o)
    else $error("read not answered next cycle");
  chk_length_value: assert property (s_len |=> wb_dat_o == 32'h00001404)
    else $error("wrong image lengths");
  chk_write_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("write ack with data");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h30
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_chan: assert property ($fell(rst_i) |-> channel_o == 4'h0)
    else $error("channels not cleared by reset");
  chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between acks");
endmodule // sched_checker
bind timed_output_scheduler sched_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .channel_o);

// File: tb/wb_master_model.sv
// classic wishbone master standing in for the backplane master
`timescale 1ns/1ps
module wb_master_model (
  input wire clk_i,
  input wire ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output bit ok);
    int n;
    begin
      @(posedge clk_i);
      {cyc_o, stb_o, we_o} <= {2'h3, w};
      adr_o <= a;
      dat_o <= d;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack_i !== 1'b1 && n < 20000);
      ok = (ack_i === 1'b1);
      {cyc_o, stb_o} <= 2'h0;
      adr_o <= ~a;
      dat_o <= ~d;
    end
  endtask
endmodule // wb_master_model

// File: tb/timed_output_scheduler_test.sv
// self-checking bench for the timed output scheduler
`timescale 1ns/1ps
`include "sched_consts.vh"
module timed_output_scheduler_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel, chan, lastp;
  logic [3:0] prev = 4'h0;
  logic [31:0] wd, rdat, lastw;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int t0;
  integer seed = 32'hdedd4e05;
  logic [31:0] exp_rd[$];
  logic [3:0] exp_ch[$];
  int exp_t[$];
  always #25 clk_i = ~clk_i;
  wb_master_model m (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wd));
  timed_output_scheduler DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .channel_o(chan));
  task conclude;
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task bad(input string s);
    $display("MISMATCH at %0t: %s", $time, s);
    n_mismatch++;
  endtask
  task cmp_rd(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) bad("read data");
  endtask
  task cmp_ch(input logic [3:0] got, input logic [3:0] e, input int t);
    n_compared++;
    if (got !== e || cyc_n < `TICK_CYCLES * t || cyc_n > `TICK_CYCLES * t + 60)
      bad("channel value or time");
  endtask
  task op(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    m.xfer(w, a, d, ok);
    if (!ok) begin
      bad("bus timeout");
      conclude;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    op(1'b0, a, 32'h0);
  endtask
  task put(input logic [7:0] a, input logic [7:0] sq, input int t);
    logic [3:0] p, q;
    begin
      p = 4'($random(seed));
      q = 4'($random(seed));
      if (p == lastp) p = ~p;
      lastp = p;
      exp_ch.push_back({p[0], p[1], p[2], p[3]});
      exp_t.push_back(t);
      lastw = {p, q, sq, t[15:0]};
      op(1'b1, a, lastw);
    end
  endtask
  task drain;
    for (int n = 0; n < 4000 && exp_ch.size() > 0; n++) @(posedge clk_i);
    if (exp_ch.size() > 0) begin
      bad("entries not executed");
      conclude;
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n <= rst_i ? 0 : cyc_n + 1;
    prev <= chan;
    if (ack && !we) cmp_rd(rdat, exp_rd.pop_front());
    if (!rst_i && chan !== prev) begin
      if (exp_ch.size() == 0) bad("unexpected channel change");
      else cmp_ch(chan, exp_ch.pop_front(), exp_t.pop_front());
    end
  end
  initial begin
    lastp = 4'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_LENGTH, 32'h00001404);
    rd(`OFS_STATUS, 32'h0000c100);
    rd(8'h30, 32'h0);
    for (int i = 0; i < 5; i++) begin
      put(8'(4 * i), (i == 4) ? 8'h45 : 8'(i + 1), 20 + 20 * i);
    end
    rd(`OFS_STATUS, 32'h0582c145);
    rd(8'h10, lastw);
    drain;
    rd(`OFS_STATUS, 32'h0080c645);
    t0 = cyc_n / `TICK_CYCLES + 60;
    for (int i = 0; i < 35; i++) begin
      if (i == 34) rd(`OFS_STATUS, 32'h2003c621);
      put(8'(4 * (i % 5)), 8'(i), (i < 18) ? t0 : t0 + 1);
    end
    drain;
    rd(`OFS_STATUS, 32'h0000e322);
    // mid-run reset clears channels, queue and status
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    lastp = 4'h0;
    rd(`OFS_STATUS, 32'h0000c100);
    put(8'h00, 8'h41, cyc_n / `TICK_CYCLES + 5);
    drain;
    rd(`OFS_STATUS, 32'h0080c241);
    conclude;
  end
endmodule // timed_output_scheduler_test
